// ---- bpcs_pkg.sv ----
// constants and types shared by the primary command and status bank
package bpcs_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_OFFSET   = 8'h04;
  localparam logic [7:0]  STS_OFFSET   = 8'h06;
  localparam logic [15:0] CMD_RESET    = 16'h0000;
  localparam logic [15:0] STS_RESET    = 16'h0020;
  localparam logic [15:0] CMD_WMASK    = 16'h0147;
  localparam logic [15:0] CMD_RO_ZERO  = 16'h02B8;
  localparam logic [15:0] STS_W1C_MASK = 16'hF900;
  localparam logic [15:0] READ_NONE    = 16'h0000;

  // ----------------------------------------------------------------
  // command field positions
  // ----------------------------------------------------------------
  localparam int CMD_IO_BIT     = 0;
  localparam int CMD_MEM_BIT    = 1;
  localparam int CMD_MASTER_BIT = 2;
  localparam int CMD_PERR_BIT   = 6;
  localparam int CMD_SERR_BIT   = 8;
  localparam int CMD_FBB_BIT    = 9;

  // ----------------------------------------------------------------
  // status field positions
  // ----------------------------------------------------------------
  localparam int STS_PAR_SEEN_BIT    = 15;
  localparam int STS_SERR_SENT_BIT   = 14;
  localparam int STS_MABORT_GOT_BIT  = 13;
  localparam int STS_TABORT_GOT_BIT  = 12;
  localparam int STS_TABORT_SENT_BIT = 11;
  localparam int STS_INIT_PAR_BIT    = 8;
  localparam int STS_FBB_BIT         = 7;

  // ----------------------------------------------------------------
  // system error cycle sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SERR_IDLE = 2'b01,
    SERR_SEND = 2'b10
  } bpcs_serr_state_t;

endpackage

// ---- bpcs_flag_if.sv ----
// carrier between the register bank and its sticky flag store
`timescale 1ns/100ps
interface bpcs_flag_if;
  logic [15:0] set;
  logic [15:0] clr;
  logic [15:0] flags;

  modport owner (
    input  set,
    input  clr,
    output flags
  );

  modport user (
    output set,
    output clr,
    input  flags
  );
endinterface

// ---- bpcs_status_flags.sv ----
// write-one-to-clear sticky flag store for the primary status register
`timescale 1ns/100ps
module bpcs_status_flags (
  input  wire logic   clock_in,
  input  wire logic   reset_in,
  input  wire logic   enable_in,
  bpcs_flag_if.owner  flag_port
);
  import bpcs_pkg::*;

  logic [15:0] flags_reg;
  logic [15:0] flags_next;

  // ----------------------------------------------------------------
  // flag update
  // ----------------------------------------------------------------
  // set is applied after clear so a same-cycle event is never lost
  always_comb begin
    flags_next = flags_reg;
    if (enable_in) begin
      flags_next = (flags_reg & ~flag_port.clr) | flag_port.set;
      flags_next = flags_next & STS_W1C_MASK;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      flags_reg <= STS_RESET & STS_W1C_MASK;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flag_port.flags = flags_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  set_beats_clear_a: assert property (
    enable_in && |(flag_port.set & flag_port.clr & STS_W1C_MASK)
    |=> |(flags_reg & $past(flag_port.set & flag_port.clr & STS_W1C_MASK)))
    else $error("flag lost when set and clear met");

  zero_write_keeps_a: assert property (
    enable_in && flag_port.clr == 16'h0000
    |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
    else $error("flag dropped without a clear");

  frozen_flags_a: assert property (
    !enable_in |=> flags_reg == $past(flags_reg))
    else $error("flags moved while disabled");
endmodule

// ---- bpcs_primary_regs.sv ----
// primary side command and status registers of the hub-to-PCI bridge
`timescale 1ns/100ps
module bpcs_primary_regs (
  input  wire logic        clock_in,
  input  wire logic        reset_in,
  input  wire logic        enable_in,
  input  wire logic        cfg_write_in,
  input  wire logic        cfg_read_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [1:0]  cfg_byte_en_in,
  input  wire logic [15:0] cfg_wdata_in,
  output logic      [15:0] cfg_rdata_out,
  output logic             cfg_rvalid_out,
  input  wire logic        hub_mem_req_in,
  input  wire logic        hub_io_req_in,
  output logic             hub_mem_claim_out,
  output logic             hub_io_claim_out,
  input  wire logic        pci_req_in,
  output logic             pci_claim_out,
  output logic             upstream_start_out,
  input  wire logic        hub_parity_err_in,
  input  wire logic        hub_initiator_in,
  output logic             parity_report_out,
  input  wire logic        master_abort_got_in,
  input  wire logic        target_abort_got_in,
  input  wire logic        target_abort_sent_in,
  input  wire logic        abort_serr_route_in,
  input  wire logic        sys_err_req_in,
  output logic             serr_cycle_req_out,
  input  wire logic        serr_cycle_ack_in,
  output logic      [15:0] command_out
);
  import bpcs_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // registers are 16 bits wide, so the low address bit selects nothing
  function automatic logic addr_hits(input logic [7:0] addr,
                                     input logic [7:0] offset);
    addr_hits = (addr[7:1] == offset[7:1]);
  endfunction

  function automatic logic [15:0] merge_bytes(input logic [15:0] old_val,
                                              input logic [15:0] new_val,
                                              input logic [1:0]  be);
    merge_bytes = old_val;
    if (be[0]) begin
      merge_bytes[7:0] = new_val[7:0];
    end
    if (be[1]) begin
      merge_bytes[15:8] = new_val[15:8];
    end
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [15:0]       cmd_reg;
  logic [15:0]       cmd_next;
  logic [15:0]       rdata_reg;
  logic [15:0]       rdata_next;
  logic              rvalid_reg;
  logic              rvalid_next;
  bpcs_serr_state_t  serr_state_reg;
  bpcs_serr_state_t  serr_state_next;
  logic              serr_pend_reg;
  logic              serr_pend_next;
  logic              cmd_wr;
  logic              sts_wr;
  logic              serr_cause;
  logic              serr_taken;
  logic [15:0]       status_view;
  logic [15:0]       sts_set;
  logic [15:0]       sts_clr;

  bpcs_flag_if flag_bus ();

  bpcs_status_flags u_flags (
    .clock_in  (clock_in),
    .reset_in  (reset_in),
    .enable_in (enable_in),
    .flag_port (flag_bus)
  );

  assign cmd_wr = enable_in && cfg_write_in && addr_hits(cfg_addr_in, CMD_OFFSET);
  assign sts_wr = enable_in && cfg_write_in && addr_hits(cfg_addr_in, STS_OFFSET);

  // ----------------------------------------------------------------
  // command register
  // ----------------------------------------------------------------
  // only the five control bits are stored; everything else is hardwired
  always_comb begin
    cmd_next = cmd_reg;
    if (cmd_wr) begin
      cmd_next = merge_bytes(cmd_reg, cfg_wdata_in, cfg_byte_en_in) & CMD_WMASK;
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      cmd_reg <= CMD_RESET;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  assign command_out = cmd_reg;

  // ----------------------------------------------------------------
  // cycle decode gating
  // ----------------------------------------------------------------
  // kept combinational so the claim lands in the request's own cycle
  assign hub_mem_claim_out  = hub_mem_req_in && cmd_reg[CMD_MEM_BIT];
  assign hub_io_claim_out   = hub_io_req_in && cmd_reg[CMD_IO_BIT];
  assign pci_claim_out      = pci_req_in && cmd_reg[CMD_MASTER_BIT];
  assign upstream_start_out = pci_req_in && cmd_reg[CMD_MASTER_BIT];
  assign parity_report_out  = hub_parity_err_in && cmd_reg[CMD_PERR_BIT];

  // ----------------------------------------------------------------
  // system error cycle sequencer
  // ----------------------------------------------------------------
  // a cause seen while a cycle is in flight waits in the pending bit
  assign serr_cause = sys_err_req_in || (target_abort_got_in && abort_serr_route_in);

  always_comb begin
    serr_state_next = serr_state_reg;
    serr_pend_next  = serr_pend_reg;
    if (enable_in) begin
      if (serr_cause && cmd_reg[CMD_SERR_BIT]) begin
        serr_pend_next = 1'b1;
      end
      if (!cmd_reg[CMD_SERR_BIT]) begin
        serr_pend_next = 1'b0;
      end
      case (serr_state_reg)
        SERR_IDLE: begin
          if (serr_pend_reg && cmd_reg[CMD_SERR_BIT]) begin
            serr_state_next = SERR_SEND;
            serr_pend_next  = serr_cause;
          end
        end
        SERR_SEND: begin
          // dropping the enable withdraws a request not yet taken
          if (serr_taken || !cmd_reg[CMD_SERR_BIT]) begin
            serr_state_next = SERR_IDLE;
          end
        end
        default: begin
          serr_state_next = SERR_IDLE;
          serr_pend_next  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      serr_state_reg <= SERR_IDLE;
      serr_pend_reg  <= 1'b0;
    end else begin
      serr_state_reg <= serr_state_next;
      serr_pend_reg  <= serr_pend_next;
    end
  end

  assign serr_cycle_req_out = (serr_state_reg == SERR_SEND) && cmd_reg[CMD_SERR_BIT];
  assign serr_taken = enable_in && serr_cycle_req_out && serr_cycle_ack_in;

  // ----------------------------------------------------------------
  // status events and clears
  // ----------------------------------------------------------------
  always_comb begin
    sts_set = 16'h0000;
    sts_clr = 16'h0000;
    sts_set[STS_PAR_SEEN_BIT]    = hub_parity_err_in;
    sts_set[STS_SERR_SENT_BIT]   = serr_taken;
    sts_set[STS_MABORT_GOT_BIT]  = master_abort_got_in;
    sts_set[STS_TABORT_GOT_BIT]  = target_abort_got_in;
    sts_set[STS_TABORT_SENT_BIT] = target_abort_sent_in;
    sts_set[STS_INIT_PAR_BIT]    = hub_parity_err_in && hub_initiator_in
                                   && cmd_reg[CMD_PERR_BIT];
    if (sts_wr) begin
      sts_clr = merge_bytes(16'h0000, cfg_wdata_in, cfg_byte_en_in) & STS_W1C_MASK;
    end
  end

  assign flag_bus.set = sts_set & STS_W1C_MASK;
  assign flag_bus.clr = sts_clr;

  // fixed bits ride on top of the sticky flags; bit 7 stays clear
  assign status_view = (flag_bus.flags & STS_W1C_MASK) | STS_RESET;

  // ----------------------------------------------------------------
  // configuration read port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = rvalid_reg;
    if (enable_in) begin
      rvalid_next = cfg_read_in;
      if (cfg_read_in) begin
        if (addr_hits(cfg_addr_in, CMD_OFFSET)) begin
          rdata_next = cmd_reg & ~CMD_RO_ZERO;
        end else if (addr_hits(cfg_addr_in, STS_OFFSET)) begin
          rdata_next = status_view;
        end else begin
          rdata_next = READ_NONE;
        end
      end
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_reg  <= READ_NONE;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign cfg_rdata_out  = rdata_reg;
  assign cfg_rvalid_out = rvalid_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  cmd_ro_bits_a: assert property (
    enable_in && cfg_write_in && addr_hits(cfg_addr_in, CMD_OFFSET)
    && cfg_byte_en_in[1] && cfg_wdata_in[CMD_FBB_BIT]
    |=> !cmd_reg[CMD_FBB_BIT])
    else $error("back-to-back enable took a write");

  cmd_read_zero_a: assert property (
    enable_in && cfg_read_in && addr_hits(cfg_addr_in, CMD_OFFSET)
    |=> cfg_rvalid_out && (cfg_rdata_out & CMD_RO_ZERO) == 16'h0000)
    else $error("hardwired command bits read nonzero");

  serr_gate_a: assert property (
    enable_in && !cmd_reg[CMD_SERR_BIT]
    |-> !serr_cycle_req_out ##1 (!serr_pend_reg && serr_state_reg == SERR_IDLE))
    else $error("system error cycle while disabled");

  // a cause already pending would launch one cycle early, so it is excluded
  serr_issue_a: assert property (
    enable_in && sys_err_req_in && cmd_reg[CMD_SERR_BIT] && !cfg_write_in
    && serr_state_reg == SERR_IDLE && !serr_pend_reg ##1 enable_in && !cfg_write_in
    |=> serr_cycle_req_out)
    else $error("system error cycle not raised");

  serr_hold_a: assert property (
    enable_in && serr_cycle_req_out && !serr_cycle_ack_in && !cmd_wr
    |=> serr_cycle_req_out)
    else $error("system error request dropped before ack");

  status_read_a: assert property (
    enable_in && cfg_read_in && addr_hits(cfg_addr_in, STS_OFFSET)
    |=> cfg_rdata_out == $past(status_view))
    else $error("status read returned stale flags");

  parity_report_a: assert property (
    hub_parity_err_in |-> parity_report_out == cmd_reg[CMD_PERR_BIT])
    else $error("parity report ignores response bit");

  upstream_pass_a: assert property (
    enable_in && cfg_write_in && addr_hits(cfg_addr_in, CMD_OFFSET) && cfg_byte_en_in[0]
    ##1 pci_req_in
    |-> pci_claim_out == $past(cfg_wdata_in[CMD_MASTER_BIT])
        && upstream_start_out == pci_claim_out)
    else $error("upstream forwarding disagrees with master bit");

  mem_decode_a: assert property (
    enable_in && cfg_write_in && addr_hits(cfg_addr_in, CMD_OFFSET) && cfg_byte_en_in[0]
    ##1 hub_mem_req_in
    |-> hub_mem_claim_out == $past(cfg_wdata_in[CMD_MEM_BIT]))
    else $error("memory claim disagrees with decode bit");

  io_decode_a: assert property (
    enable_in && cfg_write_in && addr_hits(cfg_addr_in, CMD_OFFSET) && cfg_byte_en_in[0]
    ##1 hub_io_req_in
    |-> hub_io_claim_out == $past(cfg_wdata_in[CMD_IO_BIT]))
    else $error("io claim disagrees with decode bit");

  parity_clear_a: assert property (
    enable_in && cfg_write_in && addr_hits(cfg_addr_in, STS_OFFSET)
    && cfg_byte_en_in[1] && cfg_wdata_in[STS_PAR_SEEN_BIT] && !hub_parity_err_in
    |=> !status_view[STS_PAR_SEEN_BIT])
    else $error("parity flag survived a clearing write");

  parity_set_a: assert property (
    enable_in && hub_parity_err_in |=> status_view[STS_PAR_SEEN_BIT])
    else $error("parity flag not set");

  serr_sent_a: assert property (
    enable_in && serr_cycle_req_out && serr_cycle_ack_in |=> status_view[STS_SERR_SENT_BIT])
    else $error("signalled system error flag not set");

  abort_flags_a: assert property (
    enable_in ##0 (master_abort_got_in || target_abort_got_in || target_abort_sent_in)
    |=> (status_view[STS_MABORT_GOT_BIT] || !$past(master_abort_got_in))
        && (status_view[STS_TABORT_GOT_BIT] || !$past(target_abort_got_in))
        && (status_view[STS_TABORT_SENT_BIT] || !$past(target_abort_sent_in)))
    else $error("abort flag not set");

  init_parity_a: assert property (
    $rose(status_view[STS_INIT_PAR_BIT])
    |-> $past(hub_parity_err_in && hub_initiator_in && cmd_reg[CMD_PERR_BIT]))
    else $error("initiator parity flag set without cause");

  sts_fixed_a: assert property (
    cfg_rvalid_out && $past(addr_hits(cfg_addr_in, STS_OFFSET))
    |-> !cfg_rdata_out[STS_FBB_BIT] && cfg_rdata_out[10:9] == 2'b00)
    else $error("hardwired status bits read wrong");

  serr_issued_c: cover property (
    serr_cycle_req_out && serr_cycle_ack_in ##1 status_view[STS_SERR_SENT_BIT]);

  mem_claim_c: cover property (hub_mem_claim_out ##1 pci_claim_out);

  flag_clear_c: cover property (
    status_view[STS_MABORT_GOT_BIT] ##[1:20] !status_view[STS_MABORT_GOT_BIT]);

  set_and_clear_c: cover property (sts_wr && |(sts_set & sts_clr));
endmodule

// ---- bpcs_hub_model.sv ----
// behavioural host hub model that accepts system error cycles
`timescale 1ns/100ps
module bpcs_hub_model (
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  input  wire logic [1:0] delay_in,
  input  wire logic       serr_req_in,
  output logic            serr_ack_out
);
  logic [1:0] wait_reg;
  logic [1:0] wait_next;
  logic       ack_reg;
  logic       ack_next;

  // ----------------------------------------------------------------
  // acceptance timing
  // ----------------------------------------------------------------
  // a withdrawn request restarts the wait; an ack decided in its last cycle still lands one cycle later
  always_comb begin
    wait_next = 2'h0;
    ack_next  = 1'b0;
    if (serr_req_in && !ack_reg) begin
      if (wait_reg >= delay_in) begin
        ack_next = 1'b1;
      end else begin
        wait_next = wait_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clock_in or posedge reset_in) begin
    if (reset_in) begin
      wait_reg <= 2'h0;
      ack_reg  <= 1'b0;
    end else begin
      wait_reg <= wait_next;
      ack_reg  <= ack_next;
    end
  end

  assign serr_ack_out = ack_reg;
endmodule

// ---- bpcs_tb.sv ----
// self-checking bench for the primary command and status bank
`timescale 1ns/100ps
module testbench;
  import bpcs_pkg::*;
  logic        clock_in, reset_in, enable_in, cfg_write_in, cfg_read_in;
  logic [7:0]  cfg_addr_in;
  logic [1:0]  cfg_byte_en_in, delay;
  logic [15:0] cfg_wdata_in, cfg_rdata_out, command_out, exp_cmd;
  logic        cfg_rvalid_out, hub_mem_claim_out, hub_io_claim_out, pci_claim_out;
  logic        upstream_start_out, parity_report_out, serr_cycle_req_out, serr_ack;
  logic        hub_mem_req_in, hub_io_req_in, pci_req_in, hub_initiator_in, route;
  logic [4:0]  ev;
  logic [15:0] exp_q[$];
  logic [31:0] seed;
  int          n_mismatch, n_checks;

  bpcs_primary_regs dut_u (
    .clock_in(clock_in), .reset_in(reset_in), .enable_in(enable_in),
    .cfg_write_in(cfg_write_in), .cfg_read_in(cfg_read_in), .cfg_addr_in(cfg_addr_in),
    .cfg_byte_en_in(cfg_byte_en_in), .cfg_wdata_in(cfg_wdata_in),
    .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out),
    .hub_mem_req_in(hub_mem_req_in), .hub_io_req_in(hub_io_req_in),
    .hub_mem_claim_out(hub_mem_claim_out), .hub_io_claim_out(hub_io_claim_out),
    .pci_req_in(pci_req_in), .pci_claim_out(pci_claim_out),
    .upstream_start_out(upstream_start_out), .hub_parity_err_in(ev[0]),
    .hub_initiator_in(hub_initiator_in), .parity_report_out(parity_report_out),
    .master_abort_got_in(ev[1]), .target_abort_got_in(ev[2]),
    .target_abort_sent_in(ev[3]), .abort_serr_route_in(route), .sys_err_req_in(ev[4]),
    .serr_cycle_req_out(serr_cycle_req_out), .serr_cycle_ack_in(serr_ack),
    .command_out(command_out));

  bpcs_hub_model hub_u (.clock_in(clock_in), .reset_in(reset_in), .delay_in(delay),
    .serr_req_in(serr_cycle_req_out), .serr_ack_out(serr_ack));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  always #25 clock_in = ~clock_in;

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    check16({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic cfg_write(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge clock_in);
    cfg_write_in   <= 1'b1;
    cfg_addr_in    <= a;
    cfg_wdata_in   <= d;
    cfg_byte_en_in <= be;
    @(posedge clock_in);
    cfg_write_in   <= 1'b0;
    #1;
  endtask

  // expected data is queued here, compared when the read answer appears
  task automatic cfg_read(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clock_in);
    exp_q.push_back(exp);
    cfg_read_in <= 1'b1;
    cfg_addr_in <= a;
    @(posedge clock_in);
    cfg_read_in <= 1'b0;
  endtask

  task automatic pulse(input logic [4:0] v);
    @(posedge clock_in);
    ev <= v;
    #1;
    check1(parity_report_out, v[0] & exp_cmd[CMD_PERR_BIT]);
    @(posedge clock_in);
    ev <= 5'h00;
  endtask

  task automatic serr_run(input logic [4:0] v, input logic expect_req);
    int k;
    delay = 2'(xorshift());
    pulse(v);
    for (k = 0; k < 12 && serr_cycle_req_out !== 1'b1; k++) @(posedge clock_in);
    check1(serr_cycle_req_out, expect_req);
    for (k = 0; k < 12 && serr_cycle_req_out !== 1'b0; k++) @(posedge clock_in);
    check1(serr_cycle_req_out, 1'b0);
  endtask

  always @(posedge clock_in) begin
    if (cfg_rvalid_out === 1'b1) begin
      if (exp_q.size() == 0) check16(cfg_rdata_out, 16'hFFFF);
      else check16(cfg_rdata_out, exp_q.pop_front());
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #500000;
    n_mismatch++;
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [15:0] bit8;
    int          i;
    clock_in = 0; reset_in = 1; enable_in = 1; cfg_write_in = 0; cfg_read_in = 0;
    cfg_addr_in = 8'h00; cfg_byte_en_in = 2'h0; cfg_wdata_in = 16'h0000; delay = 2'h0;
    hub_mem_req_in = 0; hub_io_req_in = 0; pci_req_in = 0; hub_initiator_in = 0;
    route = 0; ev = 5'h00; seed = 32'hCBFE; n_mismatch = 0; n_checks = 0;
    repeat (6) @(posedge clock_in);
    reset_in <= 1'b0;
    cfg_read(CMD_OFFSET, CMD_RESET);
    cfg_read(STS_OFFSET, STS_RESET);
    cfg_write(8'h08, 16'hFFFF, 2'h3);
    cfg_read(8'h08, READ_NONE);
    cfg_write(CMD_OFFSET, 16'hFFFF, 2'h3);
    check16(command_out, 16'h0147);
    cfg_read(CMD_OFFSET, 16'h0147);
    cfg_write(CMD_OFFSET, 16'h0000, 2'h1);
    check16(command_out, 16'h0100);
    @(posedge clock_in);
    enable_in <= 1'b0;
    cfg_write(CMD_OFFSET, 16'h0000, 2'h3);
    @(posedge clock_in);
    enable_in <= 1'b1;
    check16(command_out, 16'h0100);
    // random command values against random offered cycles
    for (i = 0; i < 24; i++) begin
      r = xorshift();
      cfg_write(CMD_OFFSET, r[15:0], 2'h3);
      exp_cmd = r[15:0] & CMD_WMASK;
      check16(command_out, exp_cmd);
      @(posedge clock_in);
      hub_mem_req_in <= r[16];
      hub_io_req_in  <= r[17];
      pci_req_in     <= r[18];
      #1;
      check1(hub_mem_claim_out, r[16] & exp_cmd[CMD_MEM_BIT]);
      check1(hub_io_claim_out, r[17] & exp_cmd[CMD_IO_BIT]);
      check1(pci_claim_out, r[18] & exp_cmd[CMD_MASTER_BIT]);
      check1(upstream_start_out, r[18] & exp_cmd[CMD_MASTER_BIT]);
    end
    // parity flags over response setting and initiator role
    for (i = 0; i < 4; i++) begin
      hub_initiator_in <= i[0];
      exp_cmd = i[1] ? 16'h0040 : 16'h0000;
      cfg_write(CMD_OFFSET, exp_cmd, 2'h3);
      pulse(5'h01);
      bit8 = (i == 3) ? 16'h0100 : 16'h0000;
      cfg_read(STS_OFFSET, STS_RESET | 16'h8000 | bit8);
      cfg_write(STS_OFFSET, 16'hFFFF, 2'h3);
    end
    cfg_read(STS_OFFSET, STS_RESET);
    pulse(5'h0E);
    cfg_read(STS_OFFSET, STS_RESET | 16'h3800);
    cfg_write(STS_OFFSET, 16'h2000, 2'h2);
    cfg_read(STS_OFFSET, STS_RESET | 16'h1800);
    fork
      cfg_write(STS_OFFSET, 16'h3800, 2'h3);
      pulse(5'h02);
    join
    cfg_read(STS_OFFSET, STS_RESET | 16'h2000);
    cfg_write(STS_OFFSET, 16'hFFFF, 2'h3);
    // system error cycles, enabled and blocked
    cfg_write(CMD_OFFSET, 16'h0100, 2'h3);
    serr_run(5'h10, 1'b1);
    cfg_read(STS_OFFSET, STS_RESET | 16'h4000);
    cfg_write(STS_OFFSET, 16'h4000, 2'h2);
    route <= 1'b1;
    serr_run(5'h04, 1'b1);
    cfg_read(STS_OFFSET, STS_RESET | 16'h5000);
    cfg_write(STS_OFFSET, 16'hFFFF, 2'h3);
    cfg_write(CMD_OFFSET, 16'h0000, 2'h3);
    serr_run(5'h14, 1'b0);
    cfg_read(STS_OFFSET, STS_RESET | 16'h1000);
    repeat (4) @(posedge clock_in);
    check16(16'(exp_q.size()), 16'h0000);
    final_report();
  end
endmodule
